// *** rtl/qbs_pkg.sv ***
// Shared constants and types for the burst-of-four dual-port SRAM port logic.
// Assumes one device configuration: four 18-bit words per burst location.
package qbs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int WORD_W  = 18;
  localparam int BYTE_W  = 9;
  localparam int BYTES   = 2;
  localparam int BURST   = 4;
  localparam int ADDR_W  = 18;
  localparam int LINE_W  = WORD_W * BURST;

  ////////////////////////////////////////////////////////////////////////////
  // Impedance tracking
  localparam int IMP_PERIOD_CYC = 1024;
  localparam int IMP_CNT_W      = 10;
  localparam int IMP_CODE_W     = 6;
  localparam logic [IMP_CNT_W-1:0]  IMP_CNT_LAST = IMP_CNT_W'(IMP_PERIOD_CYC - 1);
  localparam logic [IMP_CNT_W-1:0]  IMP_CNT_RST  = 10'h000;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_RST = 6'h20;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_MAX = 6'h3f;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_MIN = 6'h00;
  localparam logic [IMP_CODE_W-1:0] IMP_CODE_ONE = 6'h01;

  ////////////////////////////////////////////////////////////////////////////
  // States
  typedef enum logic [2:0] {
    QBS_RD_IDLE = 3'h1,
    QBS_RD_B0   = 3'h2,
    QBS_RD_B1   = 3'h4
  } qbs_rd_state_t;

  typedef enum logic [2:0] {
    QBS_WR_IDLE = 3'h1,
    QBS_WR_B0   = 3'h2,
    QBS_WR_B1   = 3'h4
  } qbs_wr_state_t;

  typedef enum logic [2:0] {
    QBS_LS_NONE = 3'h1,
    QBS_LS_RD   = 3'h2,
    QBS_LS_WR   = 3'h4
  } qbs_last_t;

  ////////////////////////////////////////////////////////////////////////////
  // One captured write word with its address tag and byte enables
  typedef struct packed {
    logic              vld;
    logic [ADDR_W-1:0] tag;
    logic [WORD_W-1:0] data;
    logic [BYTES-1:0]  en;
  } qbs_stage_t;

  localparam qbs_stage_t STAGE_RST = '0;

endpackage

// *** rtl/qbs_sram_ports.sv ***
// Port logic of a burst-of-four double-rate SRAM: read port, write port,
// shared address, arbitration, forwarding, array and impedance tracking.
// Assumes K and K# are complementary (K# rise = K fall), likewise C and C#,
// and that C edges never lag K edges.
//
// Operation
// - Read select low at K rise latches address
// - Four read words follow, one per output edge
// - Read on consecutive K rises: second ignored
// - Deselected read port tristates after next output clock rise
// - Write collects four words, then commits line
// - Write on consecutive K rises: second ignored
// - Deselected write port ignores write inputs
// - Byte selects sampled per word, mask bytes
// - Select zero bits 8:0, one bits 17:9
// - C and C# high at reset: single clock
// - Read returns newest data, forwarding writes
// - Dual select: idle read, alternate afterwards
// - Port selects sampled on K rise only
// - One start per K rise, read or write; pending bursts always finish
// - Impedance re-evaluated every 1024 cycles
// - Data and byte selects registered both edges
// - Read data registered on output clock edges
// - Four arrays, one location each per burst
// - Burst order offsets 00, 01, 10, 11
// - Reset: ports deselected, outputs high impedance
// - Selects active low; both high is no-op
`timescale 1ns/1ps
`default_nettype none

module qbs_sram_ports
  import qbs_pkg::*;
#(
  parameter int IMP_PERIOD = IMP_PERIOD_CYC
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  k_clk_i,
  input  wire logic                  c_clk_i,
  input  wire logic                  cn_clk_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic                  read_port_select_n_i,
  input  wire logic                  write_port_select_n_i,
  input  wire logic [BYTES-1:0]      byte_write_select_n_i,
  input  wire logic [WORD_W-1:0]     d_i,
  output logic      [WORD_W-1:0]     q_o,
  output logic                       q_oe_o,
  input  wire logic                  impedance_set_pin_i,
  output logic      [IMP_CODE_W-1:0] impedance_code_o,
  output logic                       impedance_update_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]          k_rst_sync_r;
  logic                k_rst_n;
  logic [1:0]          strap_sync_r;
  logic                single_clk_r;
  logic                out_clk;
  logic [1:0]          out_rst_sync_r;
  logic                out_rst_n;
  logic                rd_req;
  logic                wr_req;
  logic                rd_start;
  logic                wr_start;
  qbs_last_t           last_r;
  qbs_rd_state_t       rd_state_r;
  qbs_wr_state_t       wr_state_r;
  logic [ADDR_W-1:0]   rd_addr_r;
  logic [ADDR_W-1:0]   wr_addr_r;
  qbs_stage_t          stage_even_r [2];
  qbs_stage_t          stage_odd_r  [2];
  logic                neg_vld_r;
  logic                neg_idx_r;
  logic [ADDR_W-1:0]   neg_tag_r;
  logic                commit_r;
  logic [LINE_W-1:0]   mem [2**ADDR_W];
  logic [LINE_W-1:0]   commit_line;
  logic [LINE_W-1:0]   rd_line;
  logic [WORD_W-1:0]   q_pos_r;
  logic [WORD_W-1:0]   q_neg_r;
  logic [WORD_W-1:0]   q_hold_r;
  logic                oe_pos_r;
  logic                oe_neg_r;
  logic [1:0]          imp_sense_sync_r;
  logic [IMP_CNT_W-1:0] imp_cnt_r;
  logic                 imp_update_r;
  logic [IMP_CODE_W-1:0] imp_code_r;

  localparam logic [IMP_CNT_W-1:0] IMP_LAST = IMP_CNT_W'(IMP_PERIOD - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [WORD_W-1:0] merge_word(input logic [WORD_W-1:0] old_w,
                                                   input logic [WORD_W-1:0] new_w,
                                                   input logic [BYTES-1:0]  en);
    logic [WORD_W-1:0] res;
    res = old_w;
    for (int b = 0; b < BYTES; b++) begin
      if (en[b]) begin
        res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  // Even words arrive on K rise, odd words on K# rise
  function automatic qbs_stage_t stage_of(input int i);
    return (i % 2 == 0) ? stage_even_r[i/2] : stage_odd_r[i/2];
  endfunction

  function automatic logic [WORD_W-1:0] word_of(input logic [LINE_W-1:0] line, input int i);
    return line[i*WORD_W +: WORD_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset into the link domain, strap capture, output clock choice
  always_ff @(posedge k_clk_i) begin
    k_rst_sync_r <= {k_rst_sync_r[0], rstn_i};
  end
  assign k_rst_n = k_rst_sync_r[1];

  always_ff @(posedge k_clk_i) begin
    strap_sync_r <= {strap_sync_r[0], c_clk_i & cn_clk_i};
  end

  // Mode frozen outside reset
  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n) begin
      single_clk_r <= strap_sync_r[1];
    end
  end

  // Clock mux is static after reset, so no glitch in operation
  assign out_clk = single_clk_r ? k_clk_i : c_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode and arbitration
  assign rd_req = ~read_port_select_n_i;
  assign wr_req = ~write_port_select_n_i;

  always_comb begin
    rd_start = 1'b0;
    wr_start = 1'b0;
    if (rd_req && wr_req) begin
      if (last_r == QBS_LS_RD) begin
        wr_start = 1'b1;
      end else begin
        rd_start = 1'b1;
      end
    end else if (rd_req) begin
      rd_start = (last_r != QBS_LS_RD);
    end else if (wr_req) begin
      wr_start = (last_r != QBS_LS_WR);
    end
  end

  // Selects sampled on K rise only
  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n) begin
      last_r <= QBS_LS_NONE;
    end else if (rd_start) begin
      last_r <= QBS_LS_RD;
    end else if (wr_start) begin
      last_r <= QBS_LS_WR;
    end else begin
      last_r <= QBS_LS_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port sequencing
  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n) begin
      rd_state_r <= QBS_RD_IDLE;
    end else if (rd_start) begin
      rd_state_r <= QBS_RD_B0;
    end else begin
      case (rd_state_r)
        QBS_RD_B0: rd_state_r <= QBS_RD_B1;
        default:   rd_state_r <= QBS_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n) begin
      rd_addr_r <= '0;
    end else if (rd_start) begin
      rd_addr_r <= addr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write port sequencing and word capture
  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n) begin
      wr_state_r <= QBS_WR_IDLE;
    end else if (wr_start) begin
      wr_state_r <= QBS_WR_B0;
    end else begin
      case (wr_state_r)
        QBS_WR_B0: wr_state_r <= QBS_WR_B1;
        default:   wr_state_r <= QBS_WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n) begin
      wr_addr_r <= '0;
    end else if (wr_start) begin
      wr_addr_r <= addr_i;
    end
  end

  // Idle write port takes no data at all
  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n) begin
      stage_even_r[0] <= STAGE_RST;
      stage_even_r[1] <= STAGE_RST;
      neg_vld_r       <= 1'b0;
      neg_idx_r       <= 1'b0;
      neg_tag_r       <= '0;
      commit_r        <= 1'b0;
    end else begin
      neg_vld_r <= (wr_state_r != QBS_WR_IDLE);
      neg_idx_r <= (wr_state_r == QBS_WR_B1);
      neg_tag_r <= wr_addr_r;
      commit_r  <= (wr_state_r == QBS_WR_B1);
      if (wr_state_r == QBS_WR_B0) begin
        stage_even_r[0] <= '{1'b1, wr_addr_r, d_i, ~byte_write_select_n_i};
      end else if (wr_state_r == QBS_WR_B1) begin
        stage_even_r[1] <= '{1'b1, wr_addr_r, d_i, ~byte_write_select_n_i};
      end
    end
  end

  // K# rise: odd words; tag held so a new write cannot retag the last word
  always_ff @(negedge k_clk_i) begin
    if (!k_rst_n) begin
      stage_odd_r[0] <= STAGE_RST;
      stage_odd_r[1] <= STAGE_RST;
    end else if (neg_vld_r) begin
      stage_odd_r[neg_idx_r] <= '{1'b1, neg_tag_r, d_i, ~byte_write_select_n_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array: one line holds one location of each of the four word arrays
  always_comb begin
    qbs_stage_t st;
    logic [LINE_W-1:0] old_line;
    st = STAGE_RST;
    old_line = mem[stage_even_r[0].tag];
    commit_line = old_line;
    for (int i = 0; i < BURST; i++) begin
      st = stage_of(i);
      commit_line[i*WORD_W +: WORD_W] = merge_word(word_of(old_line, i), st.data, st.en);
    end
  end

  always_ff @(posedge k_clk_i) begin
    if (commit_r) begin
      mem[stage_even_r[0].tag] <= commit_line;
    end
  end

  // Staged words overlay the array so in-flight writes are visible
  always_comb begin
    qbs_stage_t st;
    logic [LINE_W-1:0] base;
    st = STAGE_RST;
    base = mem[rd_addr_r];
    rd_line = base;
    for (int i = 0; i < BURST; i++) begin
      st = stage_of(i);
      if (st.vld && st.tag == rd_addr_r) begin
        rd_line[i*WORD_W +: WORD_W] = merge_word(word_of(base, i), st.data, st.en);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers on the output clock pair
  always_ff @(posedge out_clk) begin
    out_rst_sync_r <= {out_rst_sync_r[0], k_rst_n};
  end
  assign out_rst_n = out_rst_sync_r[1];

  // Reads K-side state directly: C is taken as mesochronous to K
  always_ff @(posedge out_clk) begin
    if (!out_rst_n) begin
      q_pos_r  <= '0;
      q_hold_r <= '0;
      oe_pos_r <= 1'b0;
    end else begin
      case (rd_state_r)
        QBS_RD_B0: begin
          q_pos_r  <= word_of(rd_line, 0);
          q_hold_r <= word_of(rd_line, 1);
          oe_pos_r <= 1'b1;
        end
        QBS_RD_B1: begin
          q_pos_r  <= word_of(rd_line, 2);
          q_hold_r <= word_of(rd_line, 3);
          oe_pos_r <= 1'b1;
        end
        default: begin
          oe_pos_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge out_clk) begin
    if (!out_rst_n) begin
      q_neg_r  <= '0;
      oe_neg_r <= 1'b0;
    end else begin
      q_neg_r  <= q_hold_r;
      oe_neg_r <= oe_pos_r;
    end
  end

  // Double-rate pick: high half shows rising-edge word
  assign q_o    = out_clk ? q_pos_r  : q_neg_r;
  assign q_oe_o = out_clk ? oe_pos_r : oe_neg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Impedance tracking on the core clock
  always_ff @(posedge ref_clk_i) begin
    imp_sense_sync_r <= {imp_sense_sync_r[0], impedance_set_pin_i};
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      imp_cnt_r    <= IMP_CNT_RST;
      imp_update_r <= 1'b0;
    end else begin
      imp_update_r <= (imp_cnt_r == IMP_LAST);
      imp_cnt_r    <= (imp_cnt_r == IMP_LAST) ? IMP_CNT_RST : imp_cnt_r + IMP_CNT_W'(1);
    end
  end

  // One step per update limits output disturbance
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      imp_code_r <= IMP_CODE_RST;
    end else if (imp_update_r) begin
      if (imp_sense_sync_r[1] && imp_code_r != IMP_CODE_MAX) begin
        imp_code_r <= imp_code_r + IMP_CODE_ONE;
      end else if (!imp_sense_sync_r[1] && imp_code_r != IMP_CODE_MIN) begin
        imp_code_r <= imp_code_r - IMP_CODE_ONE;
      end
    end
  end

  assign impedance_code_o   = imp_code_r;
  assign impedance_update_o = imp_update_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_rd_burst;
    rd_state_r == QBS_RD_B0 ##1 rd_state_r == QBS_RD_B1;
  endsequence

  sequence s_wr_burst;
    wr_state_r == QBS_WR_B0 ##1 wr_state_r == QBS_WR_B1 ##1 commit_r;
  endsequence

  property p_rd_no_b2b;
    @(posedge k_clk_i) disable iff (!k_rst_n) rd_start |=> !rd_start;
  endproperty
  a_rd_no_b2b: assert property (p_rd_no_b2b) else $error("read started twice in a row");

  property p_wr_no_b2b;
    @(posedge k_clk_i) disable iff (!k_rst_n) wr_start |=> !wr_start;
  endproperty
  a_wr_no_b2b: assert property (p_wr_no_b2b) else $error("write started twice in a row");

  property p_arb_after_rd;
    @(posedge k_clk_i) disable iff (!k_rst_n)
      (rd_req && wr_req && last_r == QBS_LS_RD) |-> (wr_start && !rd_start);
  endproperty
  a_arb_after_rd: assert property (p_arb_after_rd) else $error("write lost after read");

  property p_arb_dual;
    @(posedge k_clk_i) disable iff (!k_rst_n)
      (rd_req && wr_req && last_r != QBS_LS_RD) |-> (rd_start && !wr_start);
  endproperty
  a_arb_dual: assert property (p_arb_dual) else $error("read lost in dual select");

  property p_rd_burst;
    @(posedge k_clk_i) disable iff (!k_rst_n) rd_start |=> s_rd_burst;
  endproperty
  a_rd_burst: assert property (p_rd_burst) else $error("read burst not two cycles");

  property p_wr_burst;
    @(posedge k_clk_i) disable iff (!k_rst_n)
      wr_start |=> s_wr_burst;
  endproperty
  a_wr_burst: assert property (p_wr_burst) else $error("write not committed");

  property p_wr_ignore;
    @(posedge k_clk_i) disable iff (!k_rst_n)
      (wr_state_r == QBS_WR_IDLE && !wr_start) |=> !neg_vld_r ##1 !commit_r;
  endproperty
  a_wr_ignore: assert property (p_wr_ignore) else $error("idle write port took data");

  property p_q_tristate;
    @(posedge out_clk) disable iff (!out_rst_n)
      (rd_state_r == QBS_RD_IDLE) |=> !oe_pos_r;
  endproperty
  a_q_tristate: assert property (p_q_tristate) else $error("read outputs still driven");

  property p_imp_period;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      imp_update_r |-> (imp_cnt_r == IMP_CNT_RST && $past(imp_cnt_r) == IMP_LAST);
  endproperty
  a_imp_period: assert property (p_imp_period) else $error("impedance update off period");

endmodule // qbs_sram_ports

`default_nettype wire

// *** test/qbs_ctrl_model.sv ***
// Memory controller stand-in: plays queued K-cycle slots onto the ports.
// Assumes the bench supplies K; all pins move 1 ns after a K edge.
`timescale 1ns/1ps
`default_nettype none

module qbs_ctrl_model
  import qbs_pkg::*;
(
  input  wire logic              k_clk_i,
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   rsel_n_o,
  output logic                   wsel_n_o,
  output logic [BYTES-1:0]       bws_n_o,
  output logic [WORD_W-1:0]      d_o,
  output int                     cycle_o
);
  // Slot: rsel, wsel, addr, rise word, fall word, rise selects, fall selects
  localparam int SW = 60;
  logic [SW-1:0] slot_q[$];
  logic [SW-1:0] cur;

  task push(input logic [SW-1:0] s);
    slot_q.push_back(s);
  endtask

  initial begin
    cur      = {2'b11, 58'h0};
    cycle_o  = 0;
    rsel_n_o = 1'b1;
    wsel_n_o = 1'b1;
    addr_o   = '0;
    d_o      = '0;
    bws_n_o  = '1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Values for the coming K rise; idle slots keep both selects high
  always @(negedge k_clk_i) begin
    #1;
    if (slot_q.size() > 0) begin
      cur = slot_q.pop_front();
      cycle_o++;
    end else begin
      cur = {2'b11, ~cur[57:0]};
    end
    {rsel_n_o, wsel_n_o, addr_o, d_o} = cur[59:22];
    bws_n_o = cur[3:2];
  end

  // Fall word; selects and address turn to garbage, never sampled here
  always @(posedge k_clk_i) begin
    #1;
    {rsel_n_o, wsel_n_o} = ~{rsel_n_o, wsel_n_o};
    addr_o  = ~addr_o;
    d_o     = cur[21:4];
    bws_n_o = cur[1:0];
  end
endmodule // qbs_ctrl_model

`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the burst-of-four SRAM port logic.
// Dual clock mode with C = K first, then single-clock strap after a second reset.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import qbs_pkg::*;
  localparam int IMP_P = 8;
  localparam int NS    = 1024;

  logic              ref_clk_i = 1'b0;
  logic              rstn_i    = 1'b0;
  logic              k_clk_i   = 1'b0;
  logic              pin       = 1'b1;
  logic              cn_clk;
  logic              c_clk;
  logic              strap     = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic              rsel_n, wsel_n, q_oe, upd, chk_on = 1'b0;
  logic [BYTES-1:0]  bws_n;
  logic [WORD_W-1:0] d, q;
  logic [5:0]        code, ecode;
  int                cyc, rc = -1, errors = 0, num_checks = 0, seed = 32'hf344d27f;
  int                ns = 0, prev = 0, gap = 0, npulse = 0, pend = 0;
  logic              rs_a[NS], ws_a[NS], eo_h[NS], eo_l[NS];
  int                ai_a[NS];
  logic [17:0]       dr_a[NS], df_a[NS], eq_h[NS], eq_l[NS], mem[4][4];
  logic [1:0]        br_a[NS], bf_a[NS];
  logic [17:0]       pool[4] = '{18'h00000, 18'h3ffff, 18'h15555, 18'h2aaaa};

  // Strap high parks C and C# high, so only K can time the outputs
  assign c_clk  = strap | k_clk_i;
  assign cn_clk = strap | ~k_clk_i;
  always #2 ref_clk_i = ~ref_clk_i;
  initial begin
    #3.3;
    forever #7.5 k_clk_i = ~k_clk_i;
  end

  qbs_ctrl_model ctrl (.k_clk_i(k_clk_i), .addr_o(addr), .rsel_n_o(rsel_n), .wsel_n_o(wsel_n),
                       .bws_n_o(bws_n), .d_o(d), .cycle_o(cyc));
  qbs_sram_ports #(.IMP_PERIOD(IMP_P)) dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .k_clk_i(k_clk_i), .c_clk_i(c_clk),
    .cn_clk_i(cn_clk), .addr_i(addr), .read_port_select_n_i(rsel_n),
    .write_port_select_n_i(wsel_n), .byte_write_select_n_i(bws_n), .d_i(d), .q_o(q),
    .q_oe_o(q_oe), .impedance_set_pin_i(pin), .impedance_code_o(code),
    .impedance_update_o(upd));

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [17:0] merge(logic [17:0] old, logic [17:0] nw, logic [1:0] bn);
    merge = old;
    if (!bn[0]) merge[8:0] = nw[8:0];
    if (!bn[1]) merge[17:9] = nw[17:9];
  endfunction

  task slot(input logic rs, input logic ws, input int ai, input logic full);
    rs_a[ns] = rs;
    ws_a[ns] = ws;
    ai_a[ns] = ai;
    dr_a[ns] = 18'($random(seed));
    df_a[ns] = 18'($random(seed));
    br_a[ns] = full ? 2'h0 : 2'($random(seed));
    bf_a[ns] = full ? 2'h0 : 2'($random(seed));
    {eo_h[ns], eo_l[ns]} = 2'b00;
    ns++;
  endtask

  // Reference: read wins when allowed, one start per rise, writes apply in order
  task accept(input int s0);
    int a;
    for (int c = s0; c < ns; c++) begin
      a = ai_a[c];
      if (!rs_a[c] && prev != 1) begin
        prev = 1;
        {eo_h[c+1], eo_l[c+1], eo_h[c+2], eo_l[c+2]} = 4'hf;
        {eq_h[c+1], eq_l[c+1], eq_h[c+2], eq_l[c+2]} = {mem[a][0], mem[a][1], mem[a][2], mem[a][3]};
      end else if (!ws_a[c] && prev != 2) begin
        prev = 2;
        mem[a][0] = merge(mem[a][0], dr_a[c+1], br_a[c+1]);
        mem[a][1] = merge(mem[a][1], df_a[c+1], bf_a[c+1]);
        mem[a][2] = merge(mem[a][2], dr_a[c+2], br_a[c+2]);
        mem[a][3] = merge(mem[a][3], df_a[c+2], bf_a[c+2]);
      end else begin
        prev = 0;
      end
      ctrl.push({rs_a[c], ws_a[c], pool[a], dr_a[c], df_a[c], br_a[c], bf_a[c]});
    end
  endtask

  task run_test(input int kind);
    int s0;
    s0 = ns;
    case (kind)
      0: for (int i = 0; i < 4; i++) begin
        slot(1, 0, i, 1);
        slot(1, 1, i, 1);
      end
      1: for (int i = 0; i < 8; i++) begin
        slot(0, 1, i % 4, 0);
        slot(1, 1, 0, 0);
      end
      2: repeat (3) begin
        slot(0, 1, $random(seed) & 3, 0);
        slot(0, 1, $random(seed) & 3, 0);
        slot(1, 0, $random(seed) & 3, 0);
        slot(1, 0, $random(seed) & 3, 0);
      end
      3: for (int i = 0; i < 4; i++) begin
        slot(1, 0, i, 0);
        slot(0, 1, i, 0);
        slot(1, 1, 0, 0);
      end
      4: repeat (9) slot(0, 0, $random(seed) & 3, 0);
      default: repeat (200) slot(1'($random(seed)), 1'($random(seed)), $random(seed) & 3, 0);
    endcase
    // Full selects so a trailing write never leaves unwritten bytes behind
    repeat (3) slot(1, 1, 0, 1);
    accept(s0);
    for (int i = 0; i < 4000 && cyc < ns; i++) @(posedge k_clk_i);
    check(18'(cyc >= ns), 18'h1);
    repeat (3) @(posedge k_clk_i);
    $display("test %0d done", kind);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read port: rise word shows while the output clock is high
  always @(posedge k_clk_i) begin
    #3;
    rc = cyc - 1;
    if (chk_on && rc >= 0) begin
      check({17'h0, q_oe}, {17'h0, eo_h[rc]});
      if (eo_h[rc]) check(q, eq_h[rc]);
    end
  end

  always @(negedge k_clk_i) begin
    #3;
    if (chk_on && rc >= 0) begin
      check({17'h0, q_oe}, {17'h0, eo_l[rc]});
      if (eo_l[rc]) check(q, eq_l[rc]);
    end
  end

  // Impedance: pulse spacing and saturating step; sense flips right after a pulse
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      gap = 0;
      npulse = 0;
      pend = 0;
      ecode = 6'h20;
    end else begin
      gap++;
      if (pend > 0) begin
        pend--;
        if (pend == 0) check({12'h0, code}, {12'h0, ecode});
      end
      if (upd) begin
        if (npulse > 0) check(18'(gap), 18'(IMP_P));
        gap = 0;
        npulse++;
        pend = 2;
        if (pin) ecode = (ecode == 6'h3f) ? ecode : ecode + 6'h01;
        else ecode = (ecode == 6'h00) ? ecode : ecode - 6'h01;
        if (npulse % 70 == 0) pin <= ~pin;
      end
    end
  end

  initial begin
    #40000;
    errors++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    // Reset spans K edges too, since the link domain resets through a sync
    repeat (5) @(posedge k_clk_i);
    @(posedge ref_clk_i);
    check({17'h0, q_oe}, 18'h0);
    check({12'h0, code}, 18'h20);
    check({17'h0, upd}, 18'h0);
    #1 rstn_i = 1'b1;
    repeat (6) @(posedge k_clk_i);
    chk_on = 1'b1;
    for (int k = 0; k < 6; k++) run_test(k);
    // Second reset with the single-clock strap; the array keeps its contents
    chk_on = 1'b0;
    @(posedge ref_clk_i);
    #1 rstn_i = 1'b0;
    strap = 1'b1;
    repeat (8) @(posedge k_clk_i);
    @(posedge ref_clk_i);
    check({17'h0, q_oe}, 18'h0);
    check({12'h0, code}, 18'h20);
    prev = 0;
    #1 rstn_i = 1'b1;
    repeat (6) @(posedge k_clk_i);
    chk_on = 1'b1;
    for (int k = 1; k < 5; k++) run_test(k);
    for (int i = 0; i < 3000 && npulse < 140; i++) @(posedge ref_clk_i);
    check(18'(npulse >= 140), 18'h1);
    complete_run();
  end
endmodule // tb

`default_nettype wire
